//--- hdl/asc_seq.v
// sampling, conversion and serial sequencing of a serial adc
// assumes host drives select, serial clock, serial in, frame sync and
// start strobe asynchronously; the quantiser level ain_i and both
// reference levels come from logic on sys_clk_i
`timescale 1ns/100ps
`include "asc_seq_map.vh"
module asc_seq
#(
   parameter AIN_W = 14,
   parameter FIFO_DEPTH = 4,
   parameter FIFO_AW = 2
)
(
   input wire sys_clk_i,
   input wire rstn_i,
   input wire cs_n_i,
   input wire sclk_i,
   input wire serial_in_i,
   input wire frame_sync_i,
   input wire conv_start_strobe_n_i,
   output wire serial_out_o,
   output wire serial_out_oe_o,
   input wire [3:0] conv_div_i,
   input wire [AIN_W-1:0] ain_i,
   input wire [AIN_W-1:0] ref_high_i,
   input wire [AIN_W-1:0] ref_low_i,
   output wire [2:0] chan_sel_o,
   output wire conv_busy_o,
   output wire sample_short_o
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_SAMPLE = 3'h1;
   localparam [2:0] ST_CONVERT = 3'h2;
   localparam [2:0] ST_PUSH = 3'h3;

   wire [4:0] pins_sync;
   wire s_cs_n;
   wire s_sclk;
   wire s_sdi;
   wire s_fs;
   wire s_cst_n;
   reg cs_n_q;
   reg sclk_q;
   reg fs_q;
   reg cst_n_q;
   wire sclk_rise;
   wire sclk_fall;
   wire cs_fall;
   wire cs_rise;
   wire fs_rise;
   wire cst_fall;
   wire cst_rise;

   reg mcu_mode_q;
   reg frame_act_q;
   reg [4:0] bit_cnt_q;
   reg [15:0] shift_in_q;
   reg [15:0] shift_out_q;
   reg serial_out_q;
   reg cst_early_q;
   wire frame_start;
   wire upd_edge;
   wire cmd_done;
   wire [15:0] cmd_word;

   reg [2:0] state_q;
   reg [2:0] chan_q;
   reg [11:0] result_q;
   reg [11:0] conv_cnt_q;
   reg [15:0] samp_cnt_q;
   reg sample_short_q;
   reg [11:0] clamp_code;
   wire [AIN_W-1:0] ain_diff;
   wire [3:0] div_eff;
   wire [11:0] conv_target;
   wire sample_end;

   wire fifo_in_valid;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_pop;
   wire [11:0] fifo_out_data;

   asc_sync #(.WIDTH(5)) u_sync
   (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      // select and strobe enter inverted so a reset synchroniser reads idle
      .async_i({~cs_n_i, sclk_i, serial_in_i, frame_sync_i,
         ~conv_start_strobe_n_i}),
      .sync_o(pins_sync)
   );

   assign s_cs_n = ~pins_sync[4];
   assign s_sclk = pins_sync[3];
   assign s_sdi = pins_sync[2];
   assign s_fs = pins_sync[1];
   assign s_cst_n = ~pins_sync[0];

   // edge history of the synchronised pins
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
         fs_q <= 1'b0;
         cst_n_q <= 1'b1;
      end
      else
      begin
         cs_n_q <= s_cs_n;
         sclk_q <= s_sclk;
         fs_q <= s_fs;
         cst_n_q <= s_cst_n;
      end
   end

   assign sclk_rise = s_sclk & ~sclk_q;
   assign sclk_fall = ~s_sclk & sclk_q;
   assign cs_fall = ~s_cs_n & cs_n_q;
   assign cs_rise = s_cs_n & ~cs_n_q;
   assign fs_rise = s_fs & ~fs_q & ~s_cs_n;
   assign cst_fall = ~s_cst_n & cst_n_q;
   assign cst_rise = s_cst_n & ~cst_n_q;

   // select with frame sync high opens an mcu frame; otherwise a frame
   // sync pulse under select opens a dsp frame
   assign frame_start = (cs_fall & (s_fs == `ASC_MCU_FS_LEVEL)) |
      (~mcu_mode_q & fs_rise & ~cs_fall);
   assign upd_edge = mcu_mode_q ? sclk_fall : sclk_rise;
   assign cmd_done = frame_act_q & ~s_cs_n & sclk_rise &
      (bit_cnt_q == `ASC_LAST_BIT);
   assign cmd_word = {shift_in_q[14:0], s_sdi};
   assign fifo_pop = frame_start & fifo_out_valid;

   // serial frame: shift command in, shift previous result out
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mcu_mode_q <= 1'b1;
         frame_act_q <= 1'b0;
         bit_cnt_q <= 5'h00;
         shift_in_q <= 16'h0000;
         shift_out_q <= 16'h0000;
         serial_out_q <= 1'b0;
      end
      else
      begin
         if (cs_fall)
            mcu_mode_q <= (s_fs == `ASC_MCU_FS_LEVEL);
         if (frame_start)
         begin
            frame_act_q <= 1'b1;
            bit_cnt_q <= 5'h00;
            if (fifo_out_valid)
            begin
               shift_out_q <= {fifo_out_data, 4'h0};
               serial_out_q <= fifo_out_data[11];
            end
            else
            begin
               shift_out_q <= 16'h0000;
               serial_out_q <= 1'b0;
            end
         end
         else if (cs_rise)
            frame_act_q <= 1'b0;
         else if (frame_act_q & ~s_cs_n)
         begin
            if (sclk_rise)
            begin
               shift_in_q <= cmd_word;
               bit_cnt_q <= bit_cnt_q + 5'h01;
               if (bit_cnt_q == `ASC_LAST_BIT)
                  frame_act_q <= 1'b0;
            end
            if (upd_edge)
            begin
               shift_out_q <= {shift_out_q[14:0], 1'b0};
               serial_out_q <= shift_out_q[14];
            end
         end
      end
   end

   // early start strobe within the select frame after its fifth clock, or a lone strobe while deselected and idle
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cst_early_q <= 1'b0;
      else if (frame_start)
         cst_early_q <= 1'b0;
      else if (cst_fall & ~s_cs_n & (bit_cnt_q >= `ASC_MIN_SEL_SCLK))
         cst_early_q <= 1'b1;
      else if (cst_fall & s_cs_n & (state_q == ST_IDLE))
         cst_early_q <= 1'b1;
      else if (sample_end)
         cst_early_q <= 1'b0;
   end

   // out-of-range inputs clamp instead of wrapping
   assign ain_diff = ain_i - ref_low_i;
   always @*
   begin
      if (ain_i >= ref_high_i)
         clamp_code = `ASC_CODE_FULL;
      else if (ain_i <= ref_low_i)
         clamp_code = `ASC_CODE_ZERO;
      else if (ain_diff > {{(AIN_W-12){1'b0}}, `ASC_CODE_FULL})
         clamp_code = `ASC_CODE_FULL;
      else
         clamp_code = ain_diff[11:0];
   end

   assign div_eff = (conv_div_i == 4'h0) ? `ASC_DIV_RESET : conv_div_i;
   assign conv_target = `ASC_CONV_CLKS * {8'h00, div_eff};

   // sampling ends at the strobe rise when it fell early or alone, else at select
   assign sample_end = (state_q == ST_SAMPLE) &
      (cst_early_q ? cst_rise : cs_rise);

   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_q <= ST_IDLE;
         chan_q <= 3'h0;
         result_q <= 12'h000;
         conv_cnt_q <= 12'h000;
         samp_cnt_q <= 16'h0000;
         sample_short_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               samp_cnt_q <= 16'h0000;
               if (cmd_done & (cmd_word[15:12] == `ASC_CMD_SELFTEST))
               begin
                  result_q <= `ASC_SELFTEST_CODE;
                  state_q <= ST_PUSH;
               end
               else if (cmd_done & ~cmd_word[15])
               begin
                  chan_q <= cmd_word[14:12];
                  state_q <= ST_SAMPLE;
               end
               else if (cst_fall & s_cs_n)
                  state_q <= ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
               // an early strobe measures the sample from select's rise
               if (cs_rise & cst_early_q)
                  samp_cnt_q <= 16'h0000;
               else if (samp_cnt_q != 16'hFFFF)
                  samp_cnt_q <= samp_cnt_q + 16'h0001;
               if (sample_end)
               begin
                  // short sample is flagged, the host owns the limit
                  sample_short_q <= (samp_cnt_q <
                     `ASC_SAMPLE_CYC);
                  result_q <= clamp_code;
                  conv_cnt_q <= 12'h000;
                  state_q <= ST_CONVERT;
               end
            end
            ST_CONVERT:
            begin
               // counts serial clocks; a stopped clock stalls conversion
               if (sclk_rise)
               begin
                  conv_cnt_q <= conv_cnt_q + 12'h001;
                  if (conv_cnt_q + 12'h001 >= conv_target)
                     state_q <= ST_PUSH;
               end
            end
            ST_PUSH:
            begin
               if (fifo_in_ready)
                  state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   assign fifo_in_valid = (state_q == ST_PUSH);

   asc_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo
   (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(result_q),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out_data)
   );

   assign serial_out_o = serial_out_q;
   assign serial_out_oe_o = pins_sync[4];
   assign chan_sel_o = chan_q;
   assign conv_busy_o = (state_q != ST_IDLE);
   assign sample_short_o = sample_short_q;
endmodule // asc_seq

//--- hdl/asc_seq_map.vh
// constants of the adc sample/convert sequencer
// assumes a 250 MHz system clock; included by the sequencer
//
// Overview of operation
// - self-test command D000h returns full-scale code FFFh; positive logic.
// - input above the high reference clamps to all ones.
// - input below the low reference clamps to all zeros.
// - early start strobe: sampling runs from select end to strobe rise.
// - frame sync held high selects microcontroller mode; select frames it.
// - microcontroller mode: serial out changes after falling serial clock.
// - frame-sync mode: serial out changes after rising serial clock.
// - frame sync is obeyed only while select is asserted.
`ifndef ASC_SEQ_MAP_VH
`define ASC_SEQ_MAP_VH

`define ASC_FRAME_BITS 5'h10
`define ASC_LAST_BIT 5'h0F
`define ASC_MIN_SEL_SCLK 5'h05
`define ASC_CMD_SELFTEST 4'hD
`define ASC_SELFTEST_CODE 12'hFFF
`define ASC_CODE_FULL 12'hFFF
`define ASC_CODE_ZERO 12'h000
`define ASC_MCU_FS_LEVEL 1'h1
`define ASC_CONV_CLKS 12'h00E
`define ASC_DIV_RESET 4'h1

`define ASC_CLK_PERIOD_NS 4
`define ASC_T_SAMPLE_NS 600
`define ASC_SAMPLE_CYC \
   ((`ASC_T_SAMPLE_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)

`endif

//--- hdl/asc_sync.v
// two-flop synchroniser for a group of asynchronous pins
// assumes the inputs are independent levels
`timescale 1ns/100ps
module asc_sync
#(
   parameter WIDTH = 1
)
(
   input wire sys_clk_i,
   input wire rstn_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule // asc_sync

//--- hdl/asc_fifo.v
// result fifo between the converter and the serial port
// assumes one clock; push and pop may happen in one cycle
`timescale 1ns/100ps
module asc_fifo
#(
   parameter WIDTH = 12,
   parameter DEPTH = 4,
   parameter AW = 2
)
(
   input wire sys_clk_i,
   input wire rstn_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;

   assign in_ready_o = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge sys_clk_i)
   begin
      if (push)
         mem_q[wr_q] <= in_data_i;
   end

   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               rd_q + 1'b1;
         if (push & ~pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule // asc_fifo

//--- tb/asc_host_model.sv
// host serial port model for the adc sequencer
// assumes calls start on a falling sys_clk edge
`timescale 1ns/100ps
module asc_host_model
(
   output logic cs_n_o,
   output logic sclk_o,
   output logic sdi_o,
   output logic fs_o,
   output logic stb_n_o,
   input wire logic sdo_i
);
   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      fs_o = 1'b1;
      stb_n_o = 1'b1;
   end
   // one 16-clock frame; dsp frames raise frame_sync under select
   task automatic xfer(input logic [15:0] cmd, input logic mcu,
      input logic early, input int hold, output logic [15:0] rx);
      int i;
      fs_o = 1'b1;
      #40 fs_o = mcu;
      sclk_o = ~mcu;
      #40 cs_n_o = 1'b0;
      #80 fs_o = 1'b1;
      #80;
      for (i = 15; i >= 0; i--)
      begin
         sdi_o = cmd[i];
         #40 sclk_o = ~sclk_o;
         rx[i] = sdo_i;
         fs_o = mcu;
         #80 sclk_o = ~sclk_o;
         if (early && i == 10)
            stb_n_o = 1'b0;
         #40;
      end
      sdi_o = ~sdi_o;
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      #(hold) stb_n_o = 1'b1;
   endtask
   task automatic pulses(input int n);
      repeat (n)
      begin
         #80 sclk_o = 1'b1;
         #80 sclk_o = 1'b0;
      end
   endtask
   // start strobe alone while deselected
   task automatic strobe(input int hold);
      stb_n_o = 1'b0;
      #(hold) stb_n_o = 1'b1;
   endtask
endmodule // asc_host_model

//--- tb/asc_seq_assertions.sv
// port checker for asc_seq
// assumes pins change asynchronously to sys_clk_i
`timescale 1ns/100ps
module asc_seq_assertions
(
   input wire sys_clk_i,
   input wire rstn_i,
   input wire cs_n_i,
   input wire sclk_i,
   input wire frame_sync_i,
   input wire conv_start_strobe_n_i,
   input wire serial_out_o,
   input wire serial_out_oe_o,
   input wire [2:0] chan_sel_o,
   input wire conv_busy_o,
   input wire sample_short_o
);
   logic mcu_q;
   logic [7:0] age_q;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   // mode seen at select fall; age since a sample-ending pin edge
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mcu_q <= 1'h0;
         age_q <= 8'hFF;
      end
      else
      begin
         if ($fell(cs_n_i))
            mcu_q <= frame_sync_i;
         if ($rose(cs_n_i) || $rose(conv_start_strobe_n_i))
            age_q <= 8'h00;
         else if (age_q != 8'hFF)
            age_q <= age_q + 8'h01;
      end
   end
   a_oe_idle: assert property (
      cs_n_i [*3] |=> !serial_out_oe_o) else $error("oe when idle");
   a_oe_sel: assert property (
      !cs_n_i [*4] |-> serial_out_oe_o) else $error("oe missing");
   a_mcu_edge: assert property (
      $changed(serial_out_o) && mcu_q && !cs_n_i && !$past(cs_n_i, 4)
      |-> !$past(sclk_i, 2)) else $error("mcu data edge");
   a_dsp_edge: assert property (
      $changed(serial_out_o) && !mcu_q && !cs_n_i && !$past(cs_n_i, 4)
      |-> $past(sclk_i, 2)) else $error("dsp data edge");
   a_fs_ignored: assert property (
      (cs_n_i && conv_start_strobe_n_i) [*6] ##0 !conv_busy_o
      |=> !conv_busy_o) else $error("start while idle");
   a_busy_end: assert property (
      $fell(conv_busy_o) |-> $past(sclk_i, 3)) else $error("busy end");
   a_chan_frame: assert property (
      $changed(chan_sel_o) |-> !$past(cs_n_i, 3)) else $error("chan");
   a_short_end: assert property (
      $changed(sample_short_o) |-> age_q < 8'h08) else $error("sample");
endmodule // asc_seq_assertions
bind asc_seq asc_seq_assertions u_chk (.sys_clk_i(sys_clk_i),
   .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
   .frame_sync_i(frame_sync_i),
   .conv_start_strobe_n_i(conv_start_strobe_n_i),
   .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
   .chan_sel_o(chan_sel_o), .conv_busy_o(conv_busy_o),
   .sample_short_o(sample_short_o));

//--- tb/tb.sv
// self-checking bench of the adc sequencer
// assumes the host model drives every serial pin
`timescale 1ns/100ps
`define CHK(a, b) \
   begin n_tests++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb;
   logic sys_clk_i;
   logic rstn_i;
   logic [3:0] div;
   logic [13:0] ain;
   logic [15:0] rx;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   wire cs_n, sclk, serial_in, fs, stb_n, serial_out, oe, busy, short;
   wire [2:0] chan;
   wire sdo_line;
   asc_host_model u_host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(serial_in),
      .fs_o(fs), .stb_n_o(stb_n), .sdo_i(sdo_line));
   asc_seq u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n),
      .sclk_i(sclk), .serial_in_i(serial_in), .frame_sync_i(fs),
      .conv_start_strobe_n_i(stb_n), .serial_out_o(serial_out),
      .serial_out_oe_o(oe), .conv_div_i(div), .ain_i(ain),
      .ref_high_i(14'h10FF), .ref_low_i(14'h0100), .chan_sel_o(chan),
      .conv_busy_o(busy), .sample_short_o(short));
   // a released output shows the inverse of its last bit
   assign sdo_line = oe ? serial_out : ~serial_out;
   initial
   begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         errors++;
         test_done;
      end
   end
   task test_done;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // each frame pops the code of the frame before; empty sends zeros
   task test_selftest;
      u_host.xfer(16'hD000, 1'b1, 1'b0, 0, rx);
      `CHK(rx, 16'h0000)
      repeat (3)
      begin
         u_host.xfer(16'hD000, 1'b1, 1'b0, 0, rx);
         `CHK(rx, 16'hFFF0)
      end
      u_host.xfer(16'hF000, 1'b1, 1'b0, 0, rx);
      `CHK(rx, 16'hFFF0)
      u_host.xfer(16'hF000, 1'b1, 1'b0, 0, rx);
      `CHK(rx, 16'h0000)
      $display("selftest end");
   endtask
   task test_dsp;
      u_host.xfer(16'hD000, 1'b0, 1'b0, 0, rx);
      u_host.xfer(16'hF000, 1'b0, 1'b0, 0, rx);
      `CHK(rx, 16'hFFF0)
      $display("dsp end");
   endtask
   task test_conv(input logic [13:0] a, input logic [3:0] d,
      input logic [11:0] code);
      @(negedge sys_clk_i);
      ain = a;
      div = d;
      u_host.xfer(16'h5000, 1'b1, 1'b0, 0, rx);
      `CHK(chan, 3'h5)
      u_host.pulses(14 * d - 1);
      repeat (10) @(negedge sys_clk_i);
      `CHK(busy, 1'b1)
      u_host.pulses(1);
      repeat (10) @(negedge sys_clk_i);
      `CHK(busy, 1'b0)
      u_host.xfer(16'hF000, 1'b1, 1'b0, 0, rx);
      `CHK(rx, {code, 4'h0})
      $display("conv end");
   endtask
   // strobe lowered inside the frame; sample lasts until its rise
   task test_early(input int hold, input logic exp);
      ain = 14'h0223;
      u_host.xfer(16'h3000, 1'b1, 1'b1, hold, rx);
      repeat (10) @(negedge sys_clk_i);
      `CHK(short, exp)
      `CHK(chan, 3'h3)
      u_host.pulses(14 * div);
      u_host.xfer(16'hF000, 1'b1, 1'b0, 0, rx);
      `CHK(rx, 16'h1230)
      $display("early end");
   endtask
   // strobe alone with select high samples from its fall to its rise
   task test_solo;
      ain = 14'h0345;
      u_host.strobe(800);
      repeat (10) @(negedge sys_clk_i);
      `CHK(short, 1'b0)
      `CHK(busy, 1'b1)
      u_host.pulses(14 * div);
      repeat (10) @(negedge sys_clk_i);
      `CHK(busy, 1'b0)
      u_host.xfer(16'hF000, 1'b1, 1'b0, 0, rx);
      `CHK(rx, 16'h2450)
      $display("solo end");
   endtask
   initial
   begin
      rstn_i = 1'b0;
      div = 4'h1;
      ain = 14'h0223;
      repeat (2) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      test_selftest;
      test_dsp;
      test_conv(14'h0223, 4'h1, 12'h123);
      test_conv(14'h3000, 4'h2, 12'hFFF);
      test_conv(14'h0050, 4'h3, 12'h000);
      test_early(800, 1'b0);
      test_early(200, 1'b1);
      test_early(560, 1'b1);
      test_solo;
      test_done;
   end
endmodule // tb
